// [logic/pd_map_pkg.sv]
// Purpose: constants for the fieldbus process data map
// Assumes: apb registers, one 32-bit word each
// Notes:   user registers 3 and 4 are loaded by hardware only
//
// Overview of operation
// - output word 3 source selector takes codes 0 to 7 and resets to 0.
// - code 0 sends motor current in tenths of an ampere.
// - code 1 sends output power in hundredths of a kilowatt.
// - code 2 sends digital input status, bit 0 for input 1 upward.
// - code 3 sends analog input 2 level, 0 to 1000 for 0 to 100.0 percent.
// - code 4 sends heatsink temperature, 0 to 100 for 0 to 100 degrees.
// - codes 5 and 6 send user register 1 and user register 2.
// - code 7 sends the user selected monitor value.
// - input word 4 destination code 0 drives ramp control only when ramp source is 1.
// - input word 4 destination code 1 copies word 4 into read-only user register 4.
// - input word 3 destination code 0 drives torque limit only when torque source is 3.
// - input word 3 destination code 1 drives the pid setpoint when pid enable is 1.
// - input word 3 destination code 2 copies word 3 into read-only user register 3.
// - reply extra delay holds 0 to 16 characters and resets to 0.
// - the extra delay is added to the minimum silent interval before a reply.
// - ramp source 0 uses internal ramps and 1 uses fieldbus ramps.

package pd_map_pkg;

	// ==========================================================
	// register offsets
	localparam logic [7:0] OFS_OUT3_SRC  = 8'h00;
	localparam logic [7:0] OFS_IN4_DST   = 8'h04;
	localparam logic [7:0] OFS_IN3_DST   = 8'h08;
	localparam logic [7:0] OFS_RDELAY    = 8'h0C;
	localparam logic [7:0] OFS_CONFIG    = 8'h10;
	localparam logic [7:0] OFS_USER1     = 8'h14;
	localparam logic [7:0] OFS_USER2     = 8'h18;
	localparam logic [7:0] OFS_USER3     = 8'h1C;
	localparam logic [7:0] OFS_USER4     = 8'h20;
	localparam logic [7:0] OFS_STATUS    = 8'h24;

	// ==========================================================
	// config field positions
	localparam int CFG_RAMP_BIT   = 0;
	localparam int CFG_TORQUE_LSB = 4;
	localparam int CFG_PID_BIT    = 8;

	// ==========================================================
	// codes and limits
	localparam logic [2:0] SRC_CURRENT = 3'h0;
	localparam logic [2:0] SRC_POWER   = 3'h1;
	localparam logic [2:0] SRC_DIGIN   = 3'h2;
	localparam logic [2:0] SRC_ANALOG2 = 3'h3;
	localparam logic [2:0] SRC_HEATSNK = 3'h4;
	localparam logic [2:0] SRC_USER1   = 3'h5;
	localparam logic [2:0] SRC_USER2   = 3'h6;
	localparam logic [2:0] SRC_MONITOR = 3'h7;
	localparam logic [1:0] IN3_TORQUE  = 2'h0;
	localparam logic [1:0] IN3_PID     = 2'h1;
	localparam logic [1:0] IN3_USER3   = 2'h2;
	localparam logic       IN4_RAMP    = 1'h0;
	localparam logic       IN4_USER4   = 1'h1;
	localparam logic [3:0] TORQUE_FROM_BUS = 4'h3;
	localparam logic [4:0] RDELAY_MAX  = 5'h10;
	localparam logic [5:0] SILENT_HALF_CHARS = 6'h07;

	// ==========================================================
	// reset values
	localparam logic [2:0]  RST_OUT3_SRC = 3'h0;
	localparam logic        RST_IN4_DST  = 1'h0;
	localparam logic [1:0]  RST_IN3_DST  = 2'h0;
	localparam logic [4:0]  RST_RDELAY   = 5'h00;
	localparam logic [15:0] RST_WORD     = 16'h0000;

	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b01,
		ST_WAIT = 2'b10
	} reply_state_t;

endpackage

// [logic/fieldbus_process_data_map.sv]
// Purpose: process data word mapping and modbus reply delay
// Assumes: one exchange strobe per cyclic transfer, half character tick
// Notes:   apb answers in the access cycle with no wait states
`timescale 1ns/1ps

module fieldbus_process_data_map
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        exchange,
	input  wire logic [15:0] input_word_3,
	input  wire logic [15:0] input_word_4,
	input  wire logic [15:0] motor_current,
	input  wire logic [15:0] output_power,
	input  wire logic [15:0] digital_inputs,
	input  wire logic [15:0] analog_in2_level,
	input  wire logic [15:0] heatsink_temp,
	input  wire logic [15:0] user_selected_monitor_value,
	output logic      [15:0] output_word_3,
	output logic             output_word_3_valid,
	output logic      [15:0] ramp_command,
	output logic             ramp_command_valid,
	output logic             ramp_from_fieldbus,
	output logic      [15:0] torque_command,
	output logic             torque_command_valid,
	output logic      [15:0] pid_setpoint,
	output logic             pid_setpoint_valid,
	input  wire logic        request_received,
	input  wire logic        half_char_tick,
	output logic             reply_start
);

	// ==========================================================
	// state
	typedef struct packed
	{
		logic [2:0]               out3_src;
		logic                     in4_dst;
		logic [1:0]               in3_dst;
		logic [4:0]               rdelay;
		logic                     ramp_source_setting;
		logic [3:0]               torque_source_setting;
		logic                     pid_user_setpoint_enable;
		logic [15:0]              user1;
		logic [15:0]              user2;
		logic [15:0]              user3;
		logic [15:0]              user4;
		logic [15:0]              out3;
		logic                     out3_v;
		logic [15:0]              ramp;
		logic                     ramp_v;
		logic [15:0]              torque;
		logic                     torque_v;
		logic [15:0]              pid;
		logic                     pid_v;
		logic [31:0]              rdata;
		logic                     err;
		pd_map_pkg::reply_state_t st;
		logic [5:0]               cnt;
		logic                     go;
	} state_t;

	state_t state_r;
	state_t state_nxt;

	// ==========================================================
	// helpers
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == pd_map_pkg::OFS_OUT3_SRC) || (a == pd_map_pkg::OFS_IN4_DST) ||
			(a == pd_map_pkg::OFS_IN3_DST) || (a == pd_map_pkg::OFS_RDELAY) ||
			(a == pd_map_pkg::OFS_CONFIG) || (a == pd_map_pkg::OFS_USER1) ||
			(a == pd_map_pkg::OFS_USER2) || (a == pd_map_pkg::OFS_USER3) ||
			(a == pd_map_pkg::OFS_USER4) || (a == pd_map_pkg::OFS_STATUS);
	endfunction

	function automatic logic [31:0] word16(input logic [15:0] v);
		word16 = {16'h0000, v};
	endfunction

	// places the config fields at their package positions
	function automatic logic [31:0] cfg_word(input logic r, input logic [3:0] tq, input logic p);
		cfg_word                                    = 32'h00000000;
		cfg_word[pd_map_pkg::CFG_RAMP_BIT]          = r;
		cfg_word[pd_map_pkg::CFG_TORQUE_LSB +: 4]   = tq;
		cfg_word[pd_map_pkg::CFG_PID_BIT]           = p;
	endfunction

	logic setup;
	logic wr;

	assign setup = psel && !penable;
	assign wr    = psel && penable && pwrite && mapped(paddr);

	// ==========================================================
	// next state
	always_comb
	begin
		state_nxt = state_r;
		state_nxt.out3_v   = 1'b0;
		state_nxt.ramp_v   = 1'b0;
		state_nxt.torque_v = 1'b0;
		state_nxt.pid_v    = 1'b0;
		state_nxt.go       = 1'b0;

		// apb read data and error captured in setup
		if (setup)
		begin
			state_nxt.err = !mapped(paddr);
			unique case (paddr)
				pd_map_pkg::OFS_OUT3_SRC: state_nxt.rdata = {29'h0, state_r.out3_src};
				pd_map_pkg::OFS_IN4_DST:  state_nxt.rdata = {31'h0, state_r.in4_dst};
				pd_map_pkg::OFS_IN3_DST:  state_nxt.rdata = {30'h0, state_r.in3_dst};
				pd_map_pkg::OFS_RDELAY:   state_nxt.rdata = {27'h0, state_r.rdelay};
				pd_map_pkg::OFS_CONFIG:   state_nxt.rdata = cfg_word(
					state_r.ramp_source_setting, state_r.torque_source_setting,
					state_r.pid_user_setpoint_enable);
				pd_map_pkg::OFS_USER1:    state_nxt.rdata = word16(state_r.user1);
				pd_map_pkg::OFS_USER2:    state_nxt.rdata = word16(state_r.user2);
				pd_map_pkg::OFS_USER3:    state_nxt.rdata = word16(state_r.user3);
				pd_map_pkg::OFS_USER4:    state_nxt.rdata = word16(state_r.user4);
				pd_map_pkg::OFS_STATUS:   state_nxt.rdata = {31'h0,
					state_r.st == pd_map_pkg::ST_WAIT};
				default:                  state_nxt.rdata = 32'h00000000;
			endcase
		end

		// apb writes
		if (wr)
		begin
			unique case (paddr)
				pd_map_pkg::OFS_OUT3_SRC: state_nxt.out3_src = pwdata[2:0];
				pd_map_pkg::OFS_IN4_DST:  state_nxt.in4_dst = pwdata[0];
				pd_map_pkg::OFS_IN3_DST:  state_nxt.in3_dst = pwdata[1:0];
				pd_map_pkg::OFS_RDELAY:
					state_nxt.rdelay = (pwdata[31:0] > 32'(pd_map_pkg::RDELAY_MAX)) ?
						pd_map_pkg::RDELAY_MAX : pwdata[4:0];
				pd_map_pkg::OFS_CONFIG:
				begin
					state_nxt.ramp_source_setting = pwdata[pd_map_pkg::CFG_RAMP_BIT];
					state_nxt.torque_source_setting =
						pwdata[pd_map_pkg::CFG_TORQUE_LSB +: 4];
					state_nxt.pid_user_setpoint_enable = pwdata[pd_map_pkg::CFG_PID_BIT];
				end
				pd_map_pkg::OFS_USER1:    state_nxt.user1 = pwdata[15:0];
				pd_map_pkg::OFS_USER2:    state_nxt.user2 = pwdata[15:0];
				default:
				begin
				end
			endcase
		end

		// cyclic exchange
		if (exchange)
		begin
			state_nxt.out3_v = 1'b1;
			unique case (state_r.out3_src)
				pd_map_pkg::SRC_CURRENT: state_nxt.out3 = motor_current;
				pd_map_pkg::SRC_POWER:   state_nxt.out3 = output_power;
				pd_map_pkg::SRC_DIGIN:   state_nxt.out3 = digital_inputs;
				pd_map_pkg::SRC_ANALOG2: state_nxt.out3 = analog_in2_level;
				pd_map_pkg::SRC_HEATSNK: state_nxt.out3 = heatsink_temp;
				pd_map_pkg::SRC_USER1:   state_nxt.out3 = state_r.user1;
				pd_map_pkg::SRC_USER2:   state_nxt.out3 = state_r.user2;
				pd_map_pkg::SRC_MONITOR: state_nxt.out3 = user_selected_monitor_value;
			endcase

			if (state_r.in4_dst == pd_map_pkg::IN4_RAMP)
			begin
				if (state_r.ramp_source_setting)
				begin
					state_nxt.ramp   = input_word_4;
					state_nxt.ramp_v = 1'b1;
				end
			end
			else
			begin
				state_nxt.user4 = input_word_4;
			end

			if (state_r.in3_dst == pd_map_pkg::IN3_TORQUE)
			begin
				if (state_r.torque_source_setting == pd_map_pkg::TORQUE_FROM_BUS)
				begin
					state_nxt.torque   = input_word_3;
					state_nxt.torque_v = 1'b1;
				end
			end
			else if (state_r.in3_dst == pd_map_pkg::IN3_PID)
			begin
				if (state_r.pid_user_setpoint_enable)
				begin
					state_nxt.pid   = input_word_3;
					state_nxt.pid_v = 1'b1;
				end
			end
			else if (state_r.in3_dst == pd_map_pkg::IN3_USER3)
			begin
				state_nxt.user3 = input_word_3;
			end
		end

		// reply delay in half character ticks
		unique case (state_r.st)
			pd_map_pkg::ST_IDLE:
			begin
				if (request_received)
				begin
					state_nxt.st  = pd_map_pkg::ST_WAIT;
					state_nxt.cnt = pd_map_pkg::SILENT_HALF_CHARS +
						{state_r.rdelay, 1'b0};
				end
			end
			pd_map_pkg::ST_WAIT:
			begin
				if (request_received)
				begin
					state_nxt.cnt = pd_map_pkg::SILENT_HALF_CHARS +
						{state_r.rdelay, 1'b0};
				end
				else if (half_char_tick)
				begin
					if (state_r.cnt == 6'h01)
					begin
						state_nxt.st  = pd_map_pkg::ST_IDLE;
						state_nxt.cnt = 6'h00;
						state_nxt.go  = 1'b1;
					end
					else
					begin
						state_nxt.cnt = state_r.cnt - 6'h01;
					end
				end
			end
			default:
			begin
				state_nxt.st  = pd_map_pkg::ST_IDLE;
				state_nxt.cnt = 6'h00;
			end
		endcase
	end

	// ==========================================================
	// registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r <= '0;
			state_r.out3_src <= pd_map_pkg::RST_OUT3_SRC;
			state_r.in4_dst  <= pd_map_pkg::RST_IN4_DST;
			state_r.in3_dst  <= pd_map_pkg::RST_IN3_DST;
			state_r.rdelay   <= pd_map_pkg::RST_RDELAY;
			state_r.user1    <= pd_map_pkg::RST_WORD;
			state_r.user2    <= pd_map_pkg::RST_WORD;
			state_r.user3    <= pd_map_pkg::RST_WORD;
			state_r.user4    <= pd_map_pkg::RST_WORD;
			state_r.st       <= pd_map_pkg::ST_IDLE;
		end
		else
		begin
			state_r <= state_nxt;
		end
	end

	// ==========================================================
	// outputs
	assign prdata               = state_r.rdata;
	assign pready               = 1'b1;
	assign pslverr              = psel && penable && state_r.err;
	assign output_word_3        = state_r.out3;
	assign output_word_3_valid  = state_r.out3_v;
	assign ramp_command         = state_r.ramp;
	assign ramp_command_valid   = state_r.ramp_v;
	assign ramp_from_fieldbus   = state_r.ramp_source_setting;
	assign torque_command       = state_r.torque;
	assign torque_command_valid = state_r.torque_v;
	assign pid_setpoint         = state_r.pid;
	assign pid_setpoint_valid   = state_r.pid_v;
	assign reply_start          = state_r.go;

endmodule

// [tb/pd_map_properties.sv]
// Purpose: port assertions for the process data map
// Assumes: one exchange pulse per cyclic transfer
// Notes:   bound to the design top after the checker
`timescale 1ns/1ps
module pd_map_checker
(
	input logic        pclk,
	input logic        presetn,
	input logic        exchange,
	input logic [15:0] input_word_3,
	input logic [15:0] input_word_4,
	input logic        output_word_3_valid,
	input logic [15:0] ramp_command,
	input logic        ramp_command_valid,
	input logic        ramp_from_fieldbus,
	input logic [15:0] torque_command,
	input logic        torque_command_valid,
	input logic [15:0] pid_setpoint,
	input logic        pid_setpoint_valid,
	input logic        request_received,
	input logic        reply_start
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========================================================
	// exchange timing and routing
	a_out3_pulse: assert property (exchange |=> output_word_3_valid)
		else $error("word 3 valid missing after exchange");
	a_out3_quiet: assert property (!exchange |=> !output_word_3_valid)
		else $error("word 3 valid without exchange");
	a_route_quiet: assert property (!exchange |=> !(ramp_command_valid ||
		torque_command_valid || pid_setpoint_valid)) else $error("route pulse without exchange");
	a_ramp_route: assert property (ramp_command_valid |-> $past(ramp_from_fieldbus) &&
		ramp_command == $past(input_word_4)) else $error("ramp command wrong");
	a_torque_value: assert property (torque_command_valid |->
		torque_command == $past(input_word_3) && !pid_setpoint_valid)
		else $error("torque command wrong");
	a_torque_hold: assert property (!torque_command_valid |-> $stable(torque_command))
		else $error("torque command moved without pulse");
	a_pid_value: assert property (pid_setpoint_valid |->
		pid_setpoint == $past(input_word_3)) else $error("pid setpoint wrong");
	a_pid_hold: assert property (!pid_setpoint_valid |-> $stable(pid_setpoint))
		else $error("pid setpoint moved without pulse");
	// ==========================================================
	// reply spacing
	a_reply_floor: assert property (request_received |=> !reply_start [*7])
		else $error("reply started inside silent interval");
endmodule

bind fieldbus_process_data_map pd_map_checker u_pd_map_checker (.pclk, .presetn,
	.exchange, .input_word_3, .input_word_4, .output_word_3_valid, .ramp_command,
	.ramp_command_valid, .ramp_from_fieldbus, .torque_command, .torque_command_valid,
	.pid_setpoint, .pid_setpoint_valid, .request_received, .reply_start);

// [tb/fieldbus_master.sv]
// Purpose: fieldbus master model and reply tick source
// Assumes: half character tick every third clock
// Notes:   words show their inverse once an exchange ends
`timescale 1ns/1ps
module fieldbus_master
(
	input  logic        pclk,
	input  logic        presetn,
	output logic        exchange,
	output logic [15:0] input_word_3,
	output logic [15:0] input_word_4,
	output logic        request_received,
	output logic        half_char_tick
);
	logic [1:0] div_r;
	initial
	begin
		exchange = 1'b0;
		input_word_3 = 16'h0000;
		input_word_4 = 16'h0000;
		request_received = 1'b0;
	end
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			div_r <= 2'h0;
		else
			div_r <= (div_r == 2'h2) ? 2'h0 : div_r + 2'h1;
	assign half_char_tick = (div_r == 2'h2);
	task automatic send(input logic [15:0] w3, input logic [15:0] w4);
		@(posedge pclk);
		exchange <= 1'b1;
		input_word_3 <= w3;
		input_word_4 <= w4;
		@(posedge pclk);
		exchange <= 1'b0;
		input_word_3 <= ~w3;
		input_word_4 <= ~w4;
	endtask
	task automatic request;
		@(posedge pclk);
		request_received <= 1'b1;
		@(posedge pclk);
		request_received <= 1'b0;
	endtask
endmodule

// [tb/testbench.sv]
// Purpose: self-checking bench for the process data map
// Assumes: zero wait apb, partner drives exchanges and requests
// Notes:   reset values first, then row tables, unmapped access and reset by hand
`timescale 1ns/1ps
module testbench;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, er, exchange, request_received, half_char_tick, reply_start;
	logic [15:0] input_word_3, input_word_4, output_word_3, ramp_command, torque_command;
	logic [15:0] pid_setpoint, u4, motor_current = 0, output_power = 0, digital_inputs = 0;
	logic [15:0] analog_in2_level = 0, heatsink_temp = 0, user_selected_monitor_value = 0;
	logic output_word_3_valid, ramp_command_valid, ramp_from_fieldbus;
	logic torque_command_valid, pid_setpoint_valid;
	logic [15:0] exp_out3 [8] = '{16'h0064, 16'h0190, 16'h0005, 16'h03E8, 16'h0032,
		16'h1111, 16'h2222, 16'h7777};
	logic [11:0] rt_cfg [4] = '{12'h031, 12'h020, 12'h100, 12'h000};
	logic [2:0] rt_sel [4] = '{3'h0, 3'h0, 3'h3, 3'h5};
	logic [2:0] rt_vld [4] = '{3'h6, 3'h0, 3'h1, 3'h0};
	int dly [3] = '{0, 1, 16};
	int errors = 0, samples_checked = 0, n, t;
	always #4 pclk = ~pclk;
	fieldbus_process_data_map u_fieldbus_process_data_map (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .exchange, .input_word_3,
		.input_word_4, .motor_current, .output_power, .digital_inputs, .analog_in2_level,
		.heatsink_temp, .user_selected_monitor_value, .output_word_3, .output_word_3_valid,
		.ramp_command, .ramp_command_valid, .ramp_from_fieldbus, .torque_command,
		.torque_command_valid, .pid_setpoint, .pid_setpoint_valid, .request_received,
		.half_char_tick, .reply_start);
	fieldbus_master u_fieldbus_master (.pclk, .presetn, .exchange, .input_word_3,
		.input_word_4, .request_received, .half_char_tick);
	// ==========================================================
	// helpers
	task automatic report_and_stop;
		$display("checks=%0d mismatches=%0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (t = 0; t < 50; t++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (t == 50)
		begin
			errors++;
			report_and_stop();
		end
	endtask
	// ==========================================================
	// main sequence
	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			apb(1'b0, 8'(4 * i), 32'h0);
			chk(rd, 32'h0);
		end
		$display("test reset values done");
		for (int i = 0; i < 8; i++)
		begin
			motor_current <= 16'h0064 + 16'(i);
			output_power <= 16'h0190 + 16'(i);
			digital_inputs <= 16'h0005 + 16'(i);
			analog_in2_level <= 16'h03E8 + 16'(i);
			heatsink_temp <= 16'h0032 + 16'(i);
			user_selected_monitor_value <= 16'h7777 + 16'(i);
			apb(1'b1, pd_map_pkg::OFS_USER1, 32'h1111 + 32'(i));
			apb(1'b1, pd_map_pkg::OFS_USER2, 32'h2222 + 32'(i));
			apb(1'b1, pd_map_pkg::OFS_OUT3_SRC, 32'(i));
			u_fieldbus_master.send(16'hA5A5, 16'h5A5A);
			@(posedge pclk);
			chk(output_word_3, exp_out3[i] + 16'(i));
		end
		$display("test word 3 sources done");
		u4 = 16'h0000;
		for (int i = 0; i < 4; i++)
		begin
			apb(1'b1, pd_map_pkg::OFS_CONFIG, 32'(rt_cfg[i]));
			apb(1'b1, pd_map_pkg::OFS_IN3_DST, 32'(rt_sel[i][2:1]));
			apb(1'b1, pd_map_pkg::OFS_IN4_DST, 32'(rt_sel[i][0]));
			u_fieldbus_master.send(16'hC000 + 16'(i), 16'hD000 + 16'(i));
			@(posedge pclk);
			chk({ramp_command_valid, torque_command_valid, pid_setpoint_valid}, rt_vld[i]);
			chk(ramp_from_fieldbus, 32'(rt_cfg[i][0]));
			if (rt_sel[i][0])
				u4 = 16'hD000 + 16'(i);
			apb(1'b1, pd_map_pkg::OFS_USER4, 32'hFFFF);
			apb(1'b0, pd_map_pkg::OFS_USER4, 32'h0);
			chk(rd, u4);
		end
		chk(ramp_command, 32'h0000_D000);
		chk({torque_command, pid_setpoint}, 32'hC000_C002);
		apb(1'b1, pd_map_pkg::OFS_USER3, 32'hFFFF);
		apb(1'b0, pd_map_pkg::OFS_USER3, 32'h0);
		chk(rd, 32'hC003);
		$display("test routing done");
		apb(1'b1, pd_map_pkg::OFS_RDELAY, 32'h11);
		apb(1'b0, pd_map_pkg::OFS_RDELAY, 32'h0);
		chk(rd, 32'h10);
		u_fieldbus_master.request();
		apb(1'b0, pd_map_pkg::OFS_STATUS, 32'h0);
		chk(rd, 32'h1);
		foreach (dly[k])
		begin
			apb(1'b1, pd_map_pkg::OFS_RDELAY, 32'(dly[k]));
			u_fieldbus_master.request();
			n = 0;
			for (t = 0; t < 500; t++)
			begin
				@(posedge pclk);
				if (reply_start === 1'b1)
					break;
				if (half_char_tick === 1'b1)
					n++;
			end
			if (t == 500)
			begin
				errors++;
				report_and_stop();
			end
			chk(n, 7 + 2 * dly[k]);
		end
		apb(1'b0, pd_map_pkg::OFS_STATUS, 32'h0);
		chk(rd, 32'h0);
		$display("test reply delay done");
		apb(1'b0, 8'h40, 32'h0);
		chk(er, 32'h1);
		chk(rd, 32'h0);
		apb(1'b1, pd_map_pkg::OFS_OUT3_SRC, 32'h7);
		presetn <= 1'b0;
		repeat (12) @(posedge pclk);
		chk(output_word_3, 32'h0);
		presetn <= 1'b1;
		apb(1'b0, pd_map_pkg::OFS_OUT3_SRC, 32'h0);
		chk(rd, 32'h0);
		$display("test unmapped and reset done");
		report_and_stop();
	end
endmodule
